// ### pkg/cess_pkg.sv
/*
 * cess_pkg: constants and types for the configuration nonvolatile store
 * and its shadow register bank.
 * assumes a 20 MHz system clock and a decoded register port from the
 * serial front end carrying 12-bit word addresses of 16-bit locations.
 */
package cess_pkg;
    localparam int CLK_MHZ = 20;
    // array geometry
    localparam int NVM_ROWS = 16;
    localparam int NVM_ROW_BITS = 64;
    localparam int NVM_WORD_BITS = 32;
    localparam int NVM_WORDS = NVM_ROWS * NVM_ROW_BITS / NVM_WORD_BITS;
    // shadow bank map
    localparam int SHADOW_WORDS = 24;
    localparam logic [11:0] SHADOW_FIRST = 12'h080;
    localparam logic [11:0] SHADOW_LAST = 12'h0ae;
    localparam logic [11:0] ADDR_STEP = 12'h002;
    localparam logic [11:0] NVM_COMMAND = 12'h0ea;
    localparam logic [11:0] RESYNC_REVERSE_SETUP = 12'h080;
    localparam logic [11:0] REVERSE_BRAKE_SETUP = 12'h082;
    localparam logic [11:0] STARTUP_SETUP_A = 12'h084;
    localparam logic [11:0] STARTUP_SETUP_B = 12'h086;
    localparam logic [11:0] REGULATION_SETUP_A = 12'h088;
    localparam logic [11:0] REGULATION_SETUP_B = 12'h08a;
    localparam logic [11:0] REGULATION_SETUP_C = 12'h08c;
    localparam logic [11:0] REGULATION_SETUP_D = 12'h08e;
    localparam logic [11:0] PROTECTION_SETUP_A = 12'h090;
    localparam logic [11:0] PROTECTION_SETUP_B = 12'h092;
    localparam logic [11:0] VELOCITY_CURVE_FIRST = 12'h094;
    localparam logic [11:0] VELOCITY_CURVE_SECOND = 12'h096;
    localparam logic [11:0] VELOCITY_CURVE_THIRD = 12'h098;
    localparam logic [11:0] VELOCITY_CURVE_FOURTH = 12'h09a;
    localparam logic [11:0] VELOCITY_CURVE_FIFTH = 12'h09c;
    localparam logic [11:0] VELOCITY_CURVE_LAST = 12'h09e;
    localparam logic [11:0] ALGORITHM_MISC_A = 12'h0a0;
    localparam logic [11:0] ALGORITHM_MISC_B = 12'h0a2;
    localparam logic [11:0] TERMINAL_SETUP = 12'h0a4;
    localparam logic [11:0] CHIP_SETUP_A = 12'h0a6;
    localparam logic [11:0] CHIP_SETUP_B = 12'h0a8;
    localparam logic [11:0] PERIPHERAL_SETUP = 12'h0aa;
    localparam logic [11:0] GATE_DRIVE_SETUP_A = 12'h0ac;
    localparam logic [11:0] GATE_DRIVE_SETUP_B = 12'h0ae;
    // command codes
    localparam logic [31:0] CMD_COMMIT = 32'h8a500000;
    localparam logic [31:0] CMD_LOAD = 32'h40000000;
    // command register status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REJECT_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    // reset values
    localparam logic [31:0] SHADOW_RESET = 32'h00000000;
    localparam logic [31:0] NVM_ERASED = 32'h00000000;
    // cell timing, in microseconds
    localparam int ROW_ERASE_US = 5000;
    localparam int WORD_PROG_US = 5000;
    localparam int WORD_READ_US = 1;
    localparam int ROW_ERASE_CYCLES = ROW_ERASE_US * CLK_MHZ;
    localparam int WORD_PROG_CYCLES = WORD_PROG_US * CLK_MHZ;
    localparam logic [31:0] WORD_READ_CYCLES = 32'(WORD_READ_US * CLK_MHZ);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } cess_req_type;

    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
    } cess_rsp_type;

    typedef enum {
        CESS_IDLE,
        CESS_ERASE,
        CESS_PROG,
        CESS_READ
    } cess_state_type;
endpackage

// ### logic/cess_top.sv
/*
 * cess_top: shadow register bank, nonvolatile array model and the
 * commit/load sequencer behind the serial register port.
 * assumes the serial front end hands over decoded single-cycle read and
 * write strobes, and that the motor controller reports rotation on
 * motor_spinning synchronously to sys_clk.
 */
`timescale 1ns/10ps
module cess_top #(
    parameter int ERASE_CYCLES = cess_pkg::ROW_ERASE_CYCLES,
    parameter int PROG_CYCLES = cess_pkg::WORD_PROG_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire cess_pkg::cess_req_type reg_req,
    output cess_pkg::cess_rsp_type reg_rsp,
    input wire logic motor_spinning,
    output logic nvm_busy,
    output logic [cess_pkg::SHADOW_WORDS*32-1:0] shadow_bank
);
    localparam int WORDS = cess_pkg::SHADOW_WORDS;

    cess_pkg::cess_state_type state_q;
    logic [31:0] shadow_q [WORDS];
    // one row is two adjacent words; index = 2*row + half
    logic [31:0] nvm_q [cess_pkg::NVM_WORDS];
    logic [4:0] idx_q;
    logic [31:0] timer_q;
    logic reject_q;
    logic done_q;
    cess_pkg::cess_rsp_type rsp_q;

    // address maps to a shadow slot, 16-bit locations
    function automatic logic shadow_hit(input logic [11:0] a);
        return a >= cess_pkg::SHADOW_FIRST && a <= cess_pkg::SHADOW_LAST && !a[0];
    endfunction

    // slot of a setup register; odd or unmapped places fall to slot 0,
    // so callers must gate with shadow_hit first
    function automatic logic [4:0] shadow_index(input logic [11:0] a);
        logic [4:0] slot;
        slot = 5'h00;
        case (a)
            cess_pkg::RESYNC_REVERSE_SETUP: slot = 5'h00;
            cess_pkg::REVERSE_BRAKE_SETUP: slot = 5'h01;
            cess_pkg::STARTUP_SETUP_A: slot = 5'h02;
            cess_pkg::STARTUP_SETUP_B: slot = 5'h03;
            cess_pkg::REGULATION_SETUP_A: slot = 5'h04;
            cess_pkg::REGULATION_SETUP_B: slot = 5'h05;
            cess_pkg::REGULATION_SETUP_C: slot = 5'h06;
            cess_pkg::REGULATION_SETUP_D: slot = 5'h07;
            cess_pkg::PROTECTION_SETUP_A: slot = 5'h08;
            cess_pkg::PROTECTION_SETUP_B: slot = 5'h09;
            cess_pkg::VELOCITY_CURVE_FIRST: slot = 5'h0a;
            cess_pkg::VELOCITY_CURVE_SECOND: slot = 5'h0b;
            cess_pkg::VELOCITY_CURVE_THIRD: slot = 5'h0c;
            cess_pkg::VELOCITY_CURVE_FOURTH: slot = 5'h0d;
            cess_pkg::VELOCITY_CURVE_FIFTH: slot = 5'h0e;
            cess_pkg::VELOCITY_CURVE_LAST: slot = 5'h0f;
            cess_pkg::ALGORITHM_MISC_A: slot = 5'h10;
            cess_pkg::ALGORITHM_MISC_B: slot = 5'h11;
            cess_pkg::TERMINAL_SETUP: slot = 5'h12;
            cess_pkg::CHIP_SETUP_A: slot = 5'h13;
            cess_pkg::CHIP_SETUP_B: slot = 5'h14;
            cess_pkg::PERIPHERAL_SETUP: slot = 5'h15;
            cess_pkg::GATE_DRIVE_SETUP_A: slot = 5'h16;
            cess_pkg::GATE_DRIVE_SETUP_B: slot = 5'h17;
            default: slot = 5'h00;
        endcase
        return slot;
    endfunction

    logic cmd_wr;
    logic cmd_commit;
    logic cmd_load;
    logic idle;
    logic tick_done;
    logic last_word;

    assign idle = state_q == cess_pkg::CESS_IDLE;
    assign cmd_wr = reg_req.wr && reg_req.addr == cess_pkg::NVM_COMMAND;
    assign cmd_commit = cmd_wr && idle && reg_req.wdata == cess_pkg::CMD_COMMIT;
    assign cmd_load = cmd_wr && idle && reg_req.wdata == cess_pkg::CMD_LOAD;
    assign tick_done = timer_q == 32'h00000001;
    assign last_word = idx_q == 5'(WORDS - 1);

    // sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= cess_pkg::CESS_IDLE;
            idx_q <= 5'h00;
            timer_q <= 32'h00000000;
        end else begin
            case (state_q)
                cess_pkg::CESS_IDLE: begin
                    if (cmd_commit && !motor_spinning) begin
                        state_q <= cess_pkg::CESS_ERASE;
                        idx_q <= 5'h00;
                        timer_q <= 32'(ERASE_CYCLES);
                    end else if (cmd_load && !motor_spinning) begin
                        state_q <= cess_pkg::CESS_READ;
                        idx_q <= 5'h00;
                        timer_q <= cess_pkg::WORD_READ_CYCLES;
                    end
                end
                cess_pkg::CESS_ERASE: begin
                    // cell timing stalls while the rotor turns
                    if (!motor_spinning) begin
                        if (tick_done) begin
                            state_q <= cess_pkg::CESS_PROG;
                            timer_q <= 32'(PROG_CYCLES);
                        end else begin
                            timer_q <= timer_q - 32'h00000001;
                        end
                    end
                end
                cess_pkg::CESS_PROG: begin
                    if (!motor_spinning) begin
                        if (!tick_done) begin
                            timer_q <= timer_q - 32'h00000001;
                        end else if (last_word) begin
                            state_q <= cess_pkg::CESS_IDLE;
                        end else begin
                            idx_q <= idx_q + 5'h01;
                            // next even word starts a fresh row
                            if (idx_q[0]) begin
                                state_q <= cess_pkg::CESS_ERASE;
                                timer_q <= 32'(ERASE_CYCLES);
                            end else begin
                                timer_q <= 32'(PROG_CYCLES);
                            end
                        end
                    end
                end
                cess_pkg::CESS_READ: begin
                    if (!motor_spinning) begin
                        if (!tick_done) begin
                            timer_q <= timer_q - 32'h00000001;
                        end else if (last_word) begin
                            state_q <= cess_pkg::CESS_IDLE;
                        end else begin
                            idx_q <= idx_q + 5'h01;
                            timer_q <= cess_pkg::WORD_READ_CYCLES;
                        end
                    end
                end
                default: begin
                    state_q <= cess_pkg::CESS_IDLE;
                end
            endcase
        end
    end

    // 16 rows of 64 bits as 32 words
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < cess_pkg::NVM_WORDS; i++) begin
                nvm_q[i] <= cess_pkg::NVM_ERASED;
            end
        end else if (!motor_spinning && tick_done) begin
            if (state_q == cess_pkg::CESS_ERASE) begin
                nvm_q[{idx_q[4:1], 1'b0}] <= cess_pkg::NVM_ERASED;
                nvm_q[{idx_q[4:1], 1'b1}] <= cess_pkg::NVM_ERASED;
            end
            // commit walks the full shadow bank
            if (state_q == cess_pkg::CESS_PROG) begin
                nvm_q[idx_q] <= shadow_q[idx_q];
            end
        end
    end

    // shadow bank, host writable only when idle
    // through one slot per setup register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < WORDS; i++) begin
                shadow_q[i] <= cess_pkg::SHADOW_RESET;
            end
        end else if (state_q == cess_pkg::CESS_READ) begin
            // load copies array word into shadow
            if (!motor_spinning && tick_done) begin
                shadow_q[idx_q] <= nvm_q[idx_q];
            end
        end else if (idle && reg_req.wr && shadow_hit(reg_req.addr)) begin
            shadow_q[shadow_index(reg_req.addr)] <= reg_req.wdata;
        end
    end

    // status flags, a commit or load taken while idle clears done and sets reject from motor_spinning
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reject_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (cmd_commit || cmd_load) begin
                reject_q <= motor_spinning;
                done_q <= 1'b0;
            end else if (cmd_wr && !idle) begin
                reject_q <= 1'b1;
            end
            if (!idle && !motor_spinning && tick_done && last_word &&
                state_q != cess_pkg::CESS_ERASE) begin
                done_q <= 1'b1;
            end
        end
    end

    // register port reads; no erase path exists on it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid <= reg_req.rd;
            rsp_q.rdata <= 32'h00000000;
            if (reg_req.rd && shadow_hit(reg_req.addr)) begin
                rsp_q.rdata <= shadow_q[shadow_index(reg_req.addr)];
            end else if (reg_req.rd && reg_req.addr == cess_pkg::NVM_COMMAND) begin
                rsp_q.rdata[cess_pkg::STAT_BUSY_BIT] <= !idle;
                rsp_q.rdata[cess_pkg::STAT_REJECT_BIT] <= reject_q;
                rsp_q.rdata[cess_pkg::STAT_DONE_BIT] <= done_q;
            end
        end
    end

    assign reg_rsp = rsp_q;
    assign nvm_busy = !idle;

    // settings fan out to the motor control logic
    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            shadow_bank[i*32 +: 32] = shadow_q[i];
        end
    end
endmodule

// ### bench/cess_assertions.sv
/* checker on the cess_top ports.
   assumes binding to cess_top with its cell timing parameters. */
`timescale 1ns/10ps
module cess_assertions #(
    parameter int ERASE_CYCLES = 4,
    parameter int PROG_CYCLES = 3
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire cess_pkg::cess_req_type reg_req,
    input wire cess_pkg::cess_rsp_type reg_rsp,
    input wire logic motor_spinning,
    input wire logic nvm_busy,
    input wire logic [cess_pkg::SHADOW_WORDS*32-1:0] shadow_bank
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic cmd_wr;
    assign cmd_wr = reg_req.wr && reg_req.addr == cess_pkg::NVM_COMMAND && !nvm_busy;
    read_answer_a:
        assert property (reg_rsp.valid == $past(reg_req.rd)) else $error("read answer late");
    idle_data_a:
        assert property (!reg_rsp.valid |-> reg_rsp.rdata == 32'h0) else $error("rdata not zero");
    commit_start_a:
        assert property (cmd_wr && reg_req.wdata == cess_pkg::CMD_COMMIT && !motor_spinning
            |=> nvm_busy) else $error("commit not started");
    load_start_a:
        assert property (cmd_wr && reg_req.wdata == cess_pkg::CMD_LOAD && !motor_spinning
            |=> nvm_busy) else $error("load not started");
    spin_refuse_a:
        assert property (cmd_wr && motor_spinning |=> !nvm_busy) else $error("ran while spinning");
    other_code_a:
        assert property (cmd_wr && reg_req.wdata != cess_pkg::CMD_COMMIT
            && reg_req.wdata != cess_pkg::CMD_LOAD |=> !nvm_busy) else $error("bad code ran");
    first_word_a:
        assert property (reg_req.wr && reg_req.addr == cess_pkg::SHADOW_FIRST && !nvm_busy
            |=> shadow_bank[31:0] == $past(reg_req.wdata)) else $error("word 0 not written");
    last_word_a:
        assert property (reg_req.wr && reg_req.addr == cess_pkg::SHADOW_LAST && !nvm_busy
            |=> shadow_bank[767:736] == $past(reg_req.wdata)) else $error("word 23 not written");
    shadow_hold_a:
        assert property (!nvm_busy && !reg_req.wr |=> $stable(shadow_bank))
            else $error("shadow changed idle");
    pause_hold_a:
        assert property (nvm_busy && motor_spinning |=> $stable(shadow_bank) && nvm_busy)
            else $error("no pause on spin");
    cover property (cmd_wr && reg_req.wdata == cess_pkg::CMD_COMMIT && !motor_spinning);
    cover property (cmd_wr && reg_req.wdata == cess_pkg::CMD_LOAD && !motor_spinning);
    cover property (nvm_busy && motor_spinning);
endmodule

// ### bench/cess_host.sv
/* host controller model for the register port.
   assumes strobes taken on rising edges; it drives on falling edges. */
`timescale 1ns/10ps
module cess_host (
    input wire logic sys_clk,
    output cess_pkg::cess_req_type reg_req,
    input wire cess_pkg::cess_rsp_type reg_rsp,
    input wire logic nvm_busy
);
    initial reg_req = '0;
    task automatic write_word(input logic [11:0] a, input logic [31:0] w);
        @(negedge sys_clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
        @(negedge sys_clk);
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~w};
    endtask
    task automatic read_word(input logic [11:0] a, output logic v, output logic [31:0] d);
        @(negedge sys_clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~reg_req.wdata};
        @(negedge sys_clk);
        v = reg_rsp.valid;
        d = reg_rsp.rdata;
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~reg_req.wdata};
    endtask
    task automatic wait_idle(output logic ok);
        int n;
        n = 0;
        while (nvm_busy !== 1'b0 && n < 5000) begin
            @(negedge sys_clk);
            n++;
        end
        ok = (nvm_busy === 1'b0);
    endtask
endmodule

// ### bench/testbench.sv
/* testbench for cess_top: map, commit, load, refusals.
   assumes cess_host as controller and shortened cell timing. */
`timescale 1ns/10ps
module testbench;
    localparam int ERASE = 4;
    localparam int PROG = 3;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic motor_spinning = 1'b0;
    cess_pkg::cess_req_type reg_req;
    cess_pkg::cess_rsp_type reg_rsp;
    logic nvm_busy;
    logic [cess_pkg::SHADOW_WORDS*32-1:0] shadow_bank;
    logic [cess_pkg::SHADOW_WORDS*32-1:0] snap;
    int fails = 0;
    int compares = 0;
    logic v;
    logic ok;
    logic [31:0] d;
    cess_top #(.ERASE_CYCLES(ERASE), .PROG_CYCLES(PROG)) cess_top_inst (.sys_clk(sys_clk),
        .rst(rst), .reg_req(reg_req), .reg_rsp(reg_rsp), .motor_spinning(motor_spinning),
        .nvm_busy(nvm_busy), .shadow_bank(shadow_bank));
    cess_host cess_host_inst (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .nvm_busy(nvm_busy));
    initial forever #25 sys_clk = ~sys_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic logic [31:0] pat(input int i);
        return 32'ha5000000 + 32'(i) * 32'h01010101;
    endfunction
    function automatic logic [11:0] adr(input int i);
        return cess_pkg::SHADOW_FIRST + 12'(2 * i);
    endfunction
    task automatic read_check(input logic [11:0] a, input logic [31:0] exp);
        cess_host_inst.read_word(a, v, d);
        check({31'h0, v}, 32'h1);
        check(d, exp);
    endtask
    task automatic idle_or_quit();
        cess_host_inst.wait_idle(ok);
        check({31'h0, ok}, 32'h1);
        if (!ok) end_sim();
    endtask
    task automatic s_reset_map();
        for (int i = 0; i < cess_pkg::SHADOW_WORDS; i++) read_check(adr(i), 32'h0);
        read_check(cess_pkg::NVM_COMMAND, 32'h0);
    endtask
    task automatic s_shadow_rw();
        for (int i = 0; i < cess_pkg::SHADOW_WORDS; i++) cess_host_inst.write_word(adr(i), pat(i));
        // odd and unmapped places must not alias
        cess_host_inst.write_word(12'h081, 32'hffffffff);
        cess_host_inst.write_word(12'h0b0, 32'hffffffff);
        for (int i = 0; i < cess_pkg::SHADOW_WORDS; i++) read_check(adr(i), pat(i));
        for (int i = 0; i < 24; i++) check(shadow_bank[i*32+:32], pat(i));
        read_check(cess_pkg::RESYNC_REVERSE_SETUP, pat(0));
        read_check(cess_pkg::REVERSE_BRAKE_SETUP, pat(1));
        read_check(cess_pkg::STARTUP_SETUP_B, pat(3));
        read_check(cess_pkg::REGULATION_SETUP_D, pat(7));
        read_check(cess_pkg::PROTECTION_SETUP_B, pat(9));
        read_check(cess_pkg::VELOCITY_CURVE_LAST, pat(15));
        read_check(cess_pkg::ALGORITHM_MISC_B, pat(17));
        read_check(cess_pkg::TERMINAL_SETUP, pat(18));
        read_check(cess_pkg::CHIP_SETUP_B, pat(20));
        read_check(cess_pkg::PERIPHERAL_SETUP, pat(21));
        read_check(cess_pkg::GATE_DRIVE_SETUP_A, pat(22));
        read_check(12'h081, 32'h0);
        read_check(12'h0b0, 32'h0);
    endtask
    task automatic s_commit();
        motor_spinning = 1'b1;
        cess_host_inst.write_word(cess_pkg::NVM_COMMAND, cess_pkg::CMD_COMMIT);
        check({31'h0, nvm_busy}, 32'h0);
        read_check(cess_pkg::NVM_COMMAND, 32'h2);
        motor_spinning = 1'b0;
        cess_host_inst.write_word(cess_pkg::NVM_COMMAND, cess_pkg::CMD_COMMIT);
        check({31'h0, nvm_busy}, 32'h1);
        cess_host_inst.write_word(cess_pkg::NVM_COMMAND, cess_pkg::CMD_LOAD);
        read_check(cess_pkg::NVM_COMMAND, 32'h3);
        cess_host_inst.write_word(cess_pkg::SHADOW_FIRST, 32'h0);
        idle_or_quit();
        check(shadow_bank[31:0], pat(0));
        read_check(cess_pkg::NVM_COMMAND, 32'h6);
    endtask
    task automatic s_load();
        for (int i = 0; i < cess_pkg::SHADOW_WORDS; i++) cess_host_inst.write_word(adr(i), ~pat(i));
        cess_host_inst.write_word(cess_pkg::NVM_COMMAND, 32'h12345678);
        check({31'h0, nvm_busy}, 32'h0);
        cess_host_inst.write_word(cess_pkg::NVM_COMMAND, cess_pkg::CMD_LOAD);
        check({31'h0, nvm_busy}, 32'h1);
        repeat (100) @(negedge sys_clk);
        motor_spinning = 1'b1;
        snap = shadow_bank;
        repeat (40) @(negedge sys_clk);
        for (int i = 0; i < 24; i++) check(shadow_bank[i*32+:32], snap[i*32+:32]);
        check({31'h0, nvm_busy}, 32'h1);
        motor_spinning = 1'b0;
        idle_or_quit();
        for (int i = 0; i < cess_pkg::SHADOW_WORDS; i++) read_check(adr(i), pat(i));
        read_check(cess_pkg::NVM_COMMAND, 32'h4);
    endtask
    // reset in mid-commit: sequencer and array start over
    task automatic s_mid_reset();
        cess_host_inst.write_word(cess_pkg::NVM_COMMAND, cess_pkg::CMD_COMMIT);
        check({31'h0, nvm_busy}, 32'h1);
        repeat (5) @(negedge sys_clk);
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        check({31'h0, nvm_busy}, 32'h0);
        read_check(cess_pkg::NVM_COMMAND, 32'h0);
        cess_host_inst.write_word(cess_pkg::GATE_DRIVE_SETUP_B, 32'h5a5a5a5a);
        read_check(cess_pkg::GATE_DRIVE_SETUP_B, 32'h5a5a5a5a);
        cess_host_inst.write_word(cess_pkg::NVM_COMMAND, cess_pkg::CMD_LOAD);
        check({31'h0, nvm_busy}, 32'h1);
        idle_or_quit();
        for (int i = 0; i < cess_pkg::SHADOW_WORDS; i++) begin
            read_check(adr(i), cess_pkg::NVM_ERASED);
        end
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        s_reset_map();
        s_shadow_rw();
        s_commit();
        s_load();
        s_mid_reset();
        end_sim();
    end
endmodule
bind cess_top cess_assertions #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES))
    cess_assertions_inst (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
    .reg_rsp(reg_rsp), .motor_spinning(motor_spinning), .nvm_busy(nvm_busy),
    .shadow_bank(shadow_bank));
